// ### flash_host_pkg.sv
// constants, command decode and types for the serial flash host controller
// Behaviour
// - mode 0: sample rising, shift falling edge
// - dual io: opcode one lane, rest two
// - quad io: address out, data in, four lanes
// - frame starts with select, then 8-bit opcode, except in continuous mode, which goes straight to the address
// - every byte goes most significant bit first
// - raising select ends the operation
// - three address bytes, top two bits ignored
// - 3Bh: 8 dummy clocks, two-lane data
// - 6Bh: 8 dummy clocks, four-lane data
// - BBh: 4 mode clocks, no dummy, continuous
// - EBh: 2 mode clocks, 4 dummy, continuous
// - E7h: 2 mode clocks, 2 dummy, continuous
// - 50h is an opcode-only command
package flash_host_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_PERIOD_NS = 800;
    localparam int SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int CS_GAP_NS     = 200;
    localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0]  OP_READ      = 8'h03;
    localparam logic [7:0]  OP_FAST      = 8'h0b;
    localparam logic [7:0]  OP_DUAL_OUT  = 8'h3b;
    localparam logic [7:0]  OP_DUAL_IO   = 8'hbb;
    localparam logic [7:0]  OP_QUAD_OUT  = 8'h6b;
    localparam logic [7:0]  OP_QUAD_IO   = 8'heb;
    localparam logic [7:0]  OP_QUAD_WORD = 8'he7;
    localparam logic [7:0]  OP_VSR_WREN  = 8'h50;
    localparam logic [7:0]  OP_WREN      = 8'h06;
    localparam logic [7:0]  OP_WRDI      = 8'h04;
    localparam logic [7:0]  OP_RST_EN    = 8'h66;
    localparam logic [7:0]  OP_RST       = 8'h99;
    localparam logic [7:0]  OP_PWR_DOWN  = 8'hb9;
    localparam logic [7:0]  OP_PWR_UP    = 8'hab;

    localparam logic [4:0]  OPC_BITS     = 5'd8;
    localparam logic [4:0]  ADDR_BITS    = 5'd24;
    localparam logic [4:0]  BYTE_BITS    = 5'd8;
    localparam logic [23:0] ADDR_MASK    = 24'h3f_ffff;
    localparam logic [2:0]  LANE1        = 3'd1;
    localparam logic [2:0]  LANE2        = 3'd2;
    localparam logic [2:0]  LANE4        = 3'd4;
    localparam logic [2:0]  BB_MODE_CLK  = 3'd4;
    localparam logic [2:0]  EB_MODE_CLK  = 3'd2;
    localparam logic [3:0]  FAST_DUMMY   = 4'd8;
    localparam logic [3:0]  EB_DUMMY     = 4'd4;
    localparam logic [3:0]  E7_DUMMY     = 4'd2;
    localparam logic [3:0]  PIN_IDLE_O   = 4'h0c;
    localparam logic [15:0] LEN_ONE      = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_OPC   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_MODE  = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA  = 3'b101,
        ST_END   = 3'b110
    } phase_e;

    typedef struct packed {
        logic       ok;
        logic       has_addr;
        logic [2:0] alanes;
        logic [2:0] dlanes;
        logic [2:0] mclk;
        logic [3:0] dclk;
        logic       has_data;
        logic       can_cont;
    } cmd_s;

    function automatic cmd_s cmd_decode(input logic [7:0] op);
        cmd_s c;
        c        = '0;
        c.ok     = 1'b1;
        c.alanes = LANE1;
        c.dlanes = LANE1;
        case (op)
            OP_READ: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
            end
            OP_FAST: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.dclk     = FAST_DUMMY;
            end
            OP_DUAL_OUT: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.dclk     = FAST_DUMMY;
                c.dlanes   = LANE2;
            end
            OP_QUAD_OUT: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.dclk     = FAST_DUMMY;
                c.dlanes   = LANE4;
            end
            OP_DUAL_IO: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.alanes   = LANE2;
                c.dlanes   = LANE2;
                c.mclk     = BB_MODE_CLK;
                c.can_cont = 1'b1;
            end
            OP_QUAD_IO: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.alanes   = LANE4;
                c.dlanes   = LANE4;
                c.mclk     = EB_MODE_CLK;
                c.dclk     = EB_DUMMY;
                c.can_cont = 1'b1;
            end
            OP_QUAD_WORD: begin
                c.has_addr = 1'b1;
                c.has_data = 1'b1;
                c.alanes   = LANE4;
                c.dlanes   = LANE4;
                c.mclk     = EB_MODE_CLK;
                c.dclk     = E7_DUMMY;
                c.can_cont = 1'b1;
            end
            OP_VSR_WREN, OP_WREN, OP_WRDI, OP_RST_EN, OP_RST, OP_PWR_DOWN, OP_PWR_UP: begin
                c.ok = 1'b1;
            end
            default: c.ok = 1'b0;
        endcase
        return c;
    endfunction : cmd_decode

    // clocks needed to move a number of bits over a lane count
    function automatic logic [4:0] clocks_for(input logic [4:0] bits, input logic [2:0] lanes);
        case (lanes)
            LANE4:   return bits >> 2;
            LANE2:   return bits >> 1;
            default: return bits;
        endcase
    endfunction : clocks_for
endpackage : flash_host_pkg

// ### sck_gen.sv
// serial clock divider with edge pulses, mode 0 idle low
`timescale 1ns/10ps
module sck_gen
    import flash_host_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic run,
    output logic      sck,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic [3:0] div;
        logic       sck;
        logic       rise;
        logic       fall;
    } gen_s;

    localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

    gen_s g_r;
    gen_s g_nxt;

    always_comb begin
        g_nxt      = g_r;
        g_nxt.rise = 1'b0;
        g_nxt.fall = 1'b0;
        if (!run) begin
            g_nxt.div = '0;
            g_nxt.sck = 1'b0;
        end else if (g_r.div == HALF_LAST) begin
            g_nxt.div  = '0;
            g_nxt.sck  = ~g_r.sck;
            g_nxt.rise = ~g_r.sck;
            g_nxt.fall = g_r.sck;
        end else begin
            g_nxt.div = g_r.div + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            g_r <= '0;
        end else if (clk_en) begin
            g_r <= g_nxt;
        end
    end

    assign sck  = g_r.sck;
    assign rise = g_r.rise;
    assign fall = g_r.fall;
endmodule : sck_gen

// ### flash_host.sv
// host controller that frames serial flash commands over one, two or four lanes
`timescale 1ns/10ps
module flash_host
    import flash_host_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  mode_bits,
    input  wire logic        cont,
    input  wire logic [15:0] rd_len,
    output logic             busy,
    output logic             cmd_err,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             cs_n,
    output logic             sck,
    output logic [3:0]       io_o,
    output logic [3:0]       io_oe,
    input  wire logic [3:0]  io_i
);
    typedef struct packed {
        phase_e      st;
        cmd_s        cmd;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  mode;
        logic [31:0] sh;
        logic [7:0]  rx;
        logic [4:0]  cnt;
        logic [15:0] left;
        logic [2:0]  lanes;
        logic        adv;
        logic        run;
        logic [3:0]  gap;
        logic        cs_n;
        logic        busy;
        logic        err;
        logic [7:0]  rd_data;
        logic        rd_valid;
        logic [3:0]  io_o;
        logic [3:0]  io_oe;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
    } host_s;

    host_s  s_r;
    host_s  s_nxt;
    logic   sck_rise;
    logic   sck_fall;

    sck_gen u_sck (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .run      (s_r.run),
        .sck      (sck),
        .rise     (sck_rise),
        .fall     (sck_fall)
    );

    always_comb begin
        phase_e     ns;
        logic       enter;
        logic       drv;
        logic [7:0] rx_new;
        cmd_s       c;
        ns       = s_r.st;
        enter    = 1'b0;
        drv      = 1'b0;
        rx_new   = s_r.rx;
        c        = cmd_decode(opcode);
        s_nxt    = s_r;
        s_nxt.sync1    = io_i;
        s_nxt.sync2    = s_r.sync1;
        s_nxt.err      = 1'b0;
        s_nxt.rd_valid = 1'b0;
        case (s_r.lanes)
            LANE4:   rx_new = {s_r.rx[3:0], s_r.sync2};
            LANE2:   rx_new = {s_r.rx[5:0], s_r.sync2[1:0]};
            default: rx_new = {s_r.rx[6:0], s_r.sync2[1]};
        endcase
        case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    if (!c.ok || (cont && !c.can_cont)) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.cmd  = c;
                        s_nxt.op   = opcode;
                        s_nxt.addr = addr & ADDR_MASK;
                        s_nxt.mode = mode_bits;
                        s_nxt.left = (rd_len == 16'h0000) ? LEN_ONE : rd_len;
                        s_nxt.cs_n = 1'b0;
                        s_nxt.busy = 1'b1;
                        s_nxt.run  = 1'b1;
                        s_nxt.adv  = 1'b0;
                        s_nxt.rx   = '0;
                        enter      = 1'b1;
                        ns         = cont ? ST_ADDR : ST_OPC;
                    end
                end
            end
            ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA: begin
                if (sck_rise) begin
                    s_nxt.rx  = rx_new;
                    s_nxt.cnt = s_r.cnt - 5'd1;
                    if (s_r.cnt == 5'd1) begin
                        if (s_r.st == ST_DATA) begin
                            s_nxt.rd_data  = rx_new;
                            s_nxt.rd_valid = 1'b1;
                            s_nxt.left     = s_r.left - 16'h0001;
                            s_nxt.cnt      = clocks_for(BYTE_BITS, s_r.lanes);
                            s_nxt.adv      = (s_r.left == LEN_ONE);
                        end else begin
                            s_nxt.adv = 1'b1;
                        end
                    end
                end else if (sck_fall) begin
                    if (s_r.adv) begin
                        s_nxt.adv = 1'b0;
                        enter     = 1'b1;
                        case (s_r.st)
                            ST_OPC:   ns = s_r.cmd.has_addr ? ST_ADDR : ST_END;
                            ST_ADDR:  ns = (s_r.cmd.mclk != 3'd0) ? ST_MODE :
                                           (s_r.cmd.dclk != 4'd0) ? ST_DUMMY : ST_DATA;
                            ST_MODE:  ns = (s_r.cmd.dclk != 4'd0) ? ST_DUMMY : ST_DATA;
                            ST_DUMMY: ns = ST_DATA;
                            default:  ns = ST_END;
                        endcase
                    end else begin
                        s_nxt.sh = s_r.sh << s_r.lanes;
                    end
                end
            end
            ST_END: begin
                if (s_r.gap == 4'd0) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.busy = 1'b0;
                end else begin
                    s_nxt.gap = s_r.gap - 4'd1;
                end
            end
            default: begin
                s_nxt.st   = ST_IDLE;
                s_nxt.cs_n = 1'b1;
                s_nxt.run  = 1'b0;
                s_nxt.busy = 1'b0;
            end
        endcase
        if (enter) begin
            s_nxt.st = ns;
            case (ns)
                ST_OPC: begin
                    s_nxt.cnt   = OPC_BITS;
                    s_nxt.sh    = {s_nxt.op, 24'h00_0000};
                    s_nxt.lanes = LANE1;
                end
                ST_ADDR: begin
                    s_nxt.cnt   = clocks_for(ADDR_BITS, s_nxt.cmd.alanes);
                    s_nxt.sh    = {s_nxt.addr, 8'h00};
                    s_nxt.lanes = s_nxt.cmd.alanes;
                end
                ST_MODE: begin
                    s_nxt.cnt   = {2'b00, s_nxt.cmd.mclk};
                    s_nxt.sh    = {s_nxt.mode, 24'h00_0000};
                    s_nxt.lanes = s_nxt.cmd.alanes;
                end
                ST_DUMMY: begin
                    s_nxt.cnt   = {1'b0, s_nxt.cmd.dclk};
                    s_nxt.lanes = s_nxt.cmd.alanes;
                end
                ST_DATA: begin
                    s_nxt.cnt   = clocks_for(BYTE_BITS, s_nxt.cmd.dlanes);
                    s_nxt.lanes = s_nxt.cmd.dlanes;
                end
                default: begin
                    s_nxt.run   = 1'b0;
                    s_nxt.cs_n  = 1'b1;
                    s_nxt.gap   = 4'(CS_GAP_CYC);
                    s_nxt.lanes = LANE1;
                end
            endcase
        end
        // only address, opcode and mode phases drive the data lanes
        drv = (s_nxt.st == ST_OPC) || (s_nxt.st == ST_ADDR) || (s_nxt.st == ST_MODE);
        case (s_nxt.lanes)
            LANE4: begin
                s_nxt.io_o  = s_nxt.sh[31:28];
                s_nxt.io_oe = drv ? 4'hf : 4'h0;
            end
            LANE2: begin
                s_nxt.io_o  = {2'b11, s_nxt.sh[31:30]};
                s_nxt.io_oe = {2'b11, drv, drv};
            end
            default: begin
                // protect and hold lines are held inactive high in single-lane work
                s_nxt.io_o  = {2'b11, 1'b0, s_nxt.sh[31] & drv};
                s_nxt.io_oe = {2'b11, 1'b0, drv};
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.cs_n  <= 1'b1;
            s_r.lanes <= LANE1;
            s_r.io_o  <= PIN_IDLE_O;
            s_r.io_oe <= 4'h0c;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign busy     = s_r.busy;
    assign cmd_err  = s_r.err;
    assign rd_data  = s_r.rd_data;
    assign rd_valid = s_r.rd_valid;
    assign cs_n     = s_r.cs_n;
    assign io_o     = s_r.io_o;
    assign io_oe    = s_r.io_oe;
endmodule : flash_host

// ### flash_host_assertions.sv
// checker on the flash host ports
`timescale 1ns/10ps
module flash_host_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [7:0] opcode,
    input wire logic       cont,
    input wire logic       busy,
    input wire logic       cmd_err,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe
);
    // frozen cycles are no time to the design, so they are skipped here
    default clocking cb @(posedge core_clk iff clk_en); endclocking
    default disable iff (!rst_n);
    property p_idle; cs_n |-> !sck; endproperty
    a_idle: assert property (p_idle) else $error("sck high off frame");
    property p_hi; $rose(sck) |-> sck [*4] ##1 !sck; endproperty
    a_hi: assert property (p_hi) else $error("sck high width");
    property p_lo; $fell(sck) && !cs_n |-> !sck [*4]; endproperty
    a_lo: assert property (p_lo) else $error("sck low width");
    property p_shift;
        !cs_n && !$past(cs_n) && $changed(io_o) |-> !$past(sck) && $past(sck, 2);
    endproperty
    a_shift: assert property (p_shift) else $error("lane change off fall");
    property p_msb;
        $fell(cs_n) && !$past(cont) |-> io_oe[0] && io_o[0] == $past(opcode[7]);
    endproperty
    a_msb: assert property (p_msb) else $error("first bit wrong");
    property p_err; cmd_err |-> cs_n && !busy; endproperty
    a_err: assert property (p_err) else $error("refused command framed");
    property p_turn; rd_valid |-> !cs_n && io_oe[1:0] == 2'b00; endproperty
    a_turn: assert property (p_turn) else $error("lanes driven in data");
    // select rises one cycle after the last sck fall, then the gap runs out
    property p_end;
        $rose(cs_n) |-> !$past(sck) && $past(sck, 2) ##0 busy [*3] ##1 !busy;
    endproperty
    a_end: assert property (p_end) else $error("frame end timing");
    property p_hold; $changed(rd_data) |-> rd_valid; endproperty
    a_hold: assert property (p_hold) else $error("data moved unflagged");
    c_err: cover property (cmd_err);
    c_quad: cover property (rd_valid && io_oe == 4'h0);
    c_cont: cover property ($fell(cs_n) && $past(cont));
endmodule : flash_host_chk

bind flash_host flash_host_chk flash_host_chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .opcode(opcode),
    .cont(cont), .busy(busy), .cmd_err(cmd_err), .rd_data(rd_data),
    .rd_valid(rd_valid), .cs_n(cs_n), .sck(sck), .io_o(io_o), .io_oe(io_oe)
);

// ### flash_dev_model.sv
// behavioural serial flash and its command timing table
`timescale 1ns/10ps
package flash_tbl_pkg;
    // {addr lanes, mode clocks, dummy clocks, data lanes}, zero = no phase
    function automatic logic [15:0] spec(input logic [7:0] op);
        case (op)
            8'h03:   return 16'h1001;
            8'h0b:   return 16'h1081;
            8'h3b:   return 16'h1082;
            8'h6b:   return 16'h1084;
            8'hbb:   return 16'h2402;
            8'heb:   return 16'h4244;
            8'he7:   return 16'h4224;
            default: return 16'h0000;
        endcase
    endfunction : spec
endpackage : flash_tbl_pkg

module flash_dev_model
    import flash_tbl_pkg::*;
(
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic [3:0]  pins,
    input  wire logic [7:0]  xip_op,
    output logic [3:0]       dev_o,
    output logic [3:0]       dev_oe,
    output logic [7:0]       got_op,
    output logic [23:0]      got_addr,
    output logic [7:0]       got_mode,
    output logic [15:0]      nclk
);
    logic [15:0] sp;
    logic [15:0] o_end;
    logic [15:0] a_end;
    logic [15:0] d_end;
    logic [15:0] pos;
    logic [7:0]  dat;
    logic [3:0]  lm;
    always_comb begin
        sp    = spec(got_op);
        o_end = (xip_op != 8'h00) ? 16'h0000 : 16'h0008;
        a_end = o_end + ((sp[15:12] != 4'h0) ? 16'(24 / sp[15:12]) : 16'h0000);
        d_end = a_end + 16'(sp[11:8]) + 16'(sp[7:4]);
        lm    = 4'((5'h01 << sp[15:12]) - 5'h01);
    end
    always @(posedge sck) begin
        if (!cs_n) begin
            if (nclk < o_end) begin
                got_op <= {got_op[6:0], pins[0]};
            end else if (nclk < a_end) begin
                got_addr <= (got_addr << sp[15:12]) | 24'(pins & lm);
            end else if (nclk < a_end + 16'(sp[11:8])) begin
                got_mode <= (got_mode << sp[15:12]) | 8'(pins & lm);
            end
            nclk <= nclk + 16'h0001;
        end
    end
    always @(negedge sck) begin
        if (!cs_n && sp[3:0] != 4'h0 && nclk >= d_end) begin
            pos    = (nclk - d_end) * 16'(sp[3:0]);
            dat    = got_addr[7:0] + pos[10:3];
            dat    = dat << pos[2:0];
            dev_o  <= (sp[3:0] == 4'h1) ? {2'b00, dat[7], 1'b0} : 4'(dat >> (8 - sp[3:0]));
            dev_oe <= (sp[3:0] == 4'h1) ? 4'h2 : 4'((5'h01 << sp[3:0]) - 5'h01);
        end
    end
    // any select edge releases the lanes; only selection clears the count, address and mode and loads the opcode from xip_op
    always @(cs_n) begin
        dev_oe <= 4'h0;
        if (!cs_n) begin
            nclk     <= 16'h0000;
            got_op   <= xip_op;
            got_addr <= 24'h00_0000;
            got_mode <= 8'h00;
        end
    end
endmodule : flash_dev_model

// ### test_flash_host.sv
// bench for the flash host against a behavioural flash
`timescale 1ns/10ps
module test_flash_host
    import flash_host_pkg::*;
    import flash_tbl_pkg::*;
;
    localparam int LIMIT = 40000;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        clk_en    = 1'b1;
    logic        start     = 1'b0;
    logic [7:0]  opcode    = 8'h00;
    logic [23:0] addr      = 24'h00_0000;
    logic [7:0]  mode_bits = 8'h00;
    logic        cont      = 1'b0;
    logic [15:0] rd_len    = 16'h0000;
    logic [7:0]  xip_op    = 8'h00;
    logic        gate      = 1'b0;
    logic        junk      = 1'b0;
    logic        cs_d      = 1'b1;
    logic        busy, cmd_err, rd_valid, cs_n, sck;
    logic [7:0]  rd_data, got_op, got_mode;
    logic [3:0]  io_o, io_oe, dev_o, dev_oe, pins;
    logic [23:0] got_addr;
    logic [15:0] nclk;
    logic [7:0]  byte_q[$];
    logic [55:0] frame_q[$];
    int          failures  = 0;
    int          checks    = 0;
    int          cyc       = 0;
    logic [7:0]  ops [14]  = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO,
        OP_QUAD_IO, OP_QUAD_WORD, OP_VSR_WREN, OP_WREN, OP_WRDI, OP_RST_EN, OP_RST,
        OP_PWR_DOWN, OP_PWR_UP};

    // released lanes toggle so a stray sample cannot match by luck
    assign pins = (io_o & io_oe) | (dev_o & dev_oe & ~io_oe) | ({4{junk}} & ~io_oe & ~dev_oe);

    flash_host flash_host_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
        .opcode(opcode), .addr(addr), .mode_bits(mode_bits), .cont(cont),
        .rd_len(rd_len), .busy(busy), .cmd_err(cmd_err), .rd_data(rd_data),
        .rd_valid(rd_valid), .cs_n(cs_n), .sck(sck), .io_o(io_o), .io_oe(io_oe),
        .io_i(pins)
    );
    flash_dev_model flash_dev_model_i (
        .cs_n(cs_n), .sck(sck), .pins(pins), .xip_op(xip_op), .dev_o(dev_o),
        .dev_oe(dev_oe), .got_op(got_op), .got_addr(got_addr), .got_mode(got_mode),
        .nclk(nclk)
    );

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) clk_en <= !gate || ($urandom % 4 != 0);

    task automatic wrap_up;
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_frame(input logic [55:0] got, input logic [55:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_frame

    task automatic cmd(input logic [7:0] op, input logic c, input logic [15:0] len,
                       input logic bad);
        logic [15:0] sp;
        logic [15:0] n;
        logic [23:0] a;
        logic [7:0]  m;
        int          i;
        sp = spec(op);
        a  = 24'($urandom);
        m  = 8'($urandom);
        @(posedge core_clk);
        start     <= 1'b1;
        opcode    <= op;
        addr      <= a;
        mode_bits <= m;
        cont      <= c;
        rd_len    <= len;
        xip_op    <= c ? op : 8'h00;
        do @(posedge core_clk); while (clk_en !== 1'b1);
        start <= 1'b0;
        @(negedge core_clk);
        if (bad) begin
            chk_byte({7'h00, cmd_err}, 8'h01);
        end else begin
            n = (c ? 16'h0000 : 16'h0008) + 16'(sp[11:8]) + 16'(sp[7:4]);
            n = n + ((sp[15:12] != 4'h0) ? 16'(24 / sp[15:12]) : 16'h0000);
            for (i = 0; i < ((len == 16'h0000) ? 1 : int'(len)) && sp[3:0] != 4'h0; i++) begin
                byte_q.push_back(a[7:0] + 8'(i));
                n = n + 16'(8 / sp[3:0]);
            end
            frame_q.push_back({op, (sp[15:12] != 4'h0) ? (a & 24'h3f_ffff) : 24'h00_0000,
                               (sp[11:8] != 4'h0) ? m : 8'h00, n});
            for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge core_clk);
        end
    endtask : cmd

    always @(posedge core_clk) begin
        junk <= ~junk;
        cs_d <= cs_n;
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            wrap_up();
        end
        if (clk_en && rd_valid === 1'b1) begin
            chk_byte(rd_data, (byte_q.size() > 0) ? byte_q.pop_front() : 8'hxx);
        end
        if (cs_n === 1'b1 && cs_d === 1'b0) begin
            chk_frame({got_op, got_addr, got_mode, nclk},
                      (frame_q.size() > 0) ? frame_q.pop_front() : 'x);
        end
    end

    initial begin
        void'($urandom(36));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (ops[k]) cmd(ops[k], 1'b0, 16'(k % 3), 1'b0);
        for (int k = 4; k < 7; k++) cmd(ops[k], 1'b1, 16'h0002, 1'b0);
        cmd(8'h12, 1'b0, 16'h0001, 1'b1);
        cmd(8'h02, 1'b0, 16'h0001, 1'b1);
        cmd(OP_DUAL_OUT, 1'b1, 16'h0001, 1'b1);
        gate = 1'b1;
        repeat (6) cmd(ops[$urandom % 7], 1'b0, 16'(1 + $urandom % 4), 1'b0);
        gate = 1'b0;
        repeat (8) @(posedge core_clk);
        wrap_up();
    end
endmodule : test_flash_host
